// ==== design/dma_pingpong_scatter_cycle.sv ====
`timescale 1ns/1ps
//
// Contract
// R1: Ping-pong alternates primary and alternate structures
// R2: Ping-pong task end flags done, switches
// R3: Ping-pong channel stays enabled between tasks
// R4: Cycle code 011 ping-pong, 110 scatter
// R5: Burst of 2^R transfers, then rearbitrate
// R6: Done strobe lasts exactly one cycle
// R7: Primary end sets select, alternate clears
// R8: Software refills idle structure meanwhile
// R9: Invalid structure: no data, disable, keep
// R10: Basic successor: done, disable, keep selection
// R11: Software clears select before ping-pong start
// R12: Primary copies descriptors into alternate structure
// R13: Software sets copy exponent 0010, N multiple of 4
// R14: Software aims copy destination at 0xC slot
// R15: Alternate structure words sit at fixed window
// R16: Copy writes words 0x0 to 0xC ascending
// R17: Software ends list with basic descriptor
// R18: Copy selects alternate, task end reselects primary
// R19: Restart needs software select clear first
// R20: No arbitration after copy; run task directly
// R21: Peripheral requests again after each pause
// R22: Width code 10 means word transfers
// R23: Task length is count field plus one
// R24: Bus error flags, interrupts, disables channel
module dma_pingpong_scatter_cycle (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [dma_cycle_pkg::AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [dma_cycle_pkg::NCH-1:0] DMA_REQ,
  output logic [dma_cycle_pkg::NCH-1:0] DMA_DONE,
  output logic IRQ,
  output logic MEM_REQ,
  output logic MEM_WRITE,
  output logic [31:0] MEM_ADDR,
  output logic [1:0] MEM_SIZE,
  output logic [31:0] MEM_WDATA,
  input wire logic [31:0] MEM_RDATA,
  input wire logic MEM_ACK,
  input wire logic MEM_ERR
);
  import dma_cycle_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] ctype(input logic [31:0] w);
    ctype = w[F_CT +: 3];
  endfunction
  function automatic logic [9:0] nm1(input logic [31:0] w);
    nm1 = w[F_NM1 +: NW];
  endfunction
  function automatic logic [3:0] rpow(input logic [31:0] w);
    rpow = w[F_RP +: 4];
  endfunction
  function automatic logic [1:0] shamt(input logic [1:0] sz);
    shamt = (sz == SZ_BYTE) ? 2'h0 : (sz == SZ_HALF) ? 2'h1 : 2'h2; // R22
  endfunction
  function automatic logic [4:0] didx(input logic alt, input logic [1:0] ch,
                                      input logic [1:0] w);
    didx = (alt ? 5'h0C : 5'h00) + {1'b0, ch, w};
  endfunction
  // Addresses run up to the end pointer, one width step per transfer
  function automatic logic [31:0] xaddr(input logic [31:0] e,
      input logic [9:0] n, input logic [9:0] c, input logic [1:0] sz);
    logic [9:0] r;
    r = n - c;
    xaddr = e - ({22'h0, r} << shamt(sz));
  endfunction
  function automatic logic [31:0] rep(input logic [31:0] d,
                                      input logic [1:0] sz);
    rep = (sz == SZ_BYTE) ? {4{d[7:0]}} :
          (sz == SZ_HALF) ? {2{d[15:0]}} : d;
  endfunction
  function automatic logic page_hit(input logic [11:0] a);
    page_hit = (a[11:8] == DESC_PRI_PAGE || a[11:8] == DESC_ALT_PAGE) &&
               a[7:6] == 2'h0 && a[5:4] != 2'h3;
  endfunction
  function automatic logic burst_hit(input logic [10:0] b,
                                     input logic [3:0] rp);
    burst_hit = (rp < 4'hB) && (b == (11'h001 << rp)); // R5
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  state_t st_reg, st_next;
  logic [1:0] ch_reg, ch_next;
  logic calt_reg, calt_next;
  logic [31:0] ctl_reg, ctl_next;
  logic [10:0] burst_reg, burst_next;
  logic [31:0] data_reg, data_next;
  logic int_reg, int_next;
  logic [2:0] en_reg, en_next;
  logic [2:0] alt_reg, alt_next;
  logic [2:0] pend_reg, pend_next;
  logic [5:0] ie_reg, ie_next;
  logic [5:0] flag_reg, flag_next;
  logic [2:0] done_reg, done_next;
  logic irq_reg, irq_next;
  logic [9:0] cnt_reg [0:7];
  logic [9:0] cnt_next [0:7];
  logic [31:0] desc_reg [0:23];
  logic mreq_reg, mreq_next;
  logic mwr_reg, mwr_next;
  logic [31:0] maddr_reg, maddr_next;
  logic [1:0] msize_reg, msize_next;
  logic [31:0] mwdata_reg, mwdata_next;
  logic [31:0] prdata_reg, prdata_next;
  logic slverr_reg, slverr_next;
  logic dwe;
  logic [4:0] dwi;
  logic [31:0] dwd;
  logic [2:0] rise;

  req_sync #(.W(NCH)) i_req_sync (
    .clk(CORE_CLK),
    .nrst(NRST),
    .async_in(DMA_REQ),
    .rise(rise)
  );

  logic f_alt, alt_cur, en_cur, wr_done, is_last, is_copy, hit;
  logic apb_wr, apb_setup, sw_en, sw_alt;
  logic [2:0] c_idx;
  logic [9:0] cn;
  logic [10:0] bst;
  logic [31:0] fctl, dst_a;

  assign f_alt = alt_reg[ch_reg];
  assign alt_cur = alt_reg[ch_reg];
  assign en_cur = en_reg[ch_reg];
  assign c_idx = {ch_reg, calt_reg};
  assign fctl = desc_reg[didx(f_alt, ch_reg, W_CTRL)];
  assign cn = cnt_reg[c_idx] + 10'h001;
  assign bst = burst_reg + 11'h001;
  assign is_last = cnt_reg[c_idx] == nm1(ctl_reg); // R23
  assign is_copy = !calt_reg && ctype(ctl_reg) == CT_PSG; // R12
  assign hit = burst_hit(bst, rpow(ctl_reg));
  assign wr_done = st_reg == ST_WR && (int_reg || (MEM_ACK && !MEM_ERR));
  // A copy walks the four words of one structure, however long the list is
  assign dst_a = is_copy ? xaddr(desc_reg[didx(calt_reg, ch_reg, W_DST)],
      10'h003, {8'h00, cnt_reg[c_idx][1:0]}, SZ_WORD) : // R16 R22
      xaddr(desc_reg[didx(calt_reg, ch_reg, W_DST)],
      nm1(ctl_reg), cnt_reg[c_idx], ctl_reg[F_DS +: 2]);
  assign apb_setup = PSEL && !PENABLE;
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign sw_en = apb_wr && PADDR == OFF_CH_EN;
  assign sw_alt = apb_wr && (PADDR == OFF_ALT_SET || PADDR == OFF_ALT_CLR);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [2:0] en_clr, a_set, a_clr, gnt_v, clr_pend;
    logic [5:0] set_flag, w1c;
    en_clr = 3'h0;
    a_set = 3'h0;
    a_clr = 3'h0;
    clr_pend = 3'h0;
    set_flag = 6'h00;
    w1c = 6'h00;
    gnt_v = pend_reg & en_reg;
    st_next = st_reg;
    ch_next = ch_reg;
    calt_next = calt_reg;
    ctl_next = ctl_reg;
    burst_next = burst_reg;
    data_next = data_reg;
    int_next = int_reg;
    done_next = 3'h0;
    cnt_next = cnt_reg;
    mreq_next = mreq_reg;
    mwr_next = mwr_reg;
    maddr_next = maddr_reg;
    msize_next = msize_reg;
    mwdata_next = mwdata_reg;
    dwe = 1'b0;
    dwi = 5'h00;
    dwd = data_reg;
    case (st_reg)
      ST_IDLE: begin
        // Lower channel number wins
        if (gnt_v != 3'h0) begin
          ch_next = gnt_v[0] ? 2'h0 : gnt_v[1] ? 2'h1 : 2'h2;
          clr_pend[ch_next] = 1'b1;
          st_next = ST_FETCH;
        end
      end
      ST_FETCH: begin
        ctl_next = fctl;
        calt_next = f_alt;
        burst_next = 11'h000;
        st_next = ST_IDLE;
        if (en_cur) begin
          case (ctype(fctl)) // R4
            CT_BASIC, CT_PINGPONG, CT_PSG: begin // R1
              mreq_next = 1'b1;
              mwr_next = 1'b0;
              msize_next = fctl[F_SS +: 2];
              maddr_next = xaddr(desc_reg[didx(f_alt, ch_reg, W_SRC)],
                  nm1(fctl), cnt_reg[{ch_reg, f_alt}], fctl[F_SS +: 2]);
              st_next = ST_RD;
            end
            default: en_clr[ch_reg] = 1'b1; // R9
          endcase
        end
      end
      ST_RD: begin
        if (MEM_ACK) begin
          mreq_next = 1'b0;
          if (MEM_ERR) begin
            set_flag[ERR_LSB + ch_reg] = 1'b1; // R24
            en_clr[ch_reg] = 1'b1; // R24
            st_next = ST_IDLE;
          end else begin
            // Replication follows the source width
            data_next = rep(MEM_RDATA, ctl_reg[F_SS +: 2]);
            maddr_next = dst_a;
            // Writes into the structure window stay on chip
            int_next = dst_a[31:12] == DESC_SYS_PAGE &&
                       page_hit(dst_a[11:0]); // R12 R14 R15
            mreq_next = !int_next;
            mwr_next = 1'b1;
            msize_next = ctl_reg[F_DS +: 2];
            mwdata_next = data_next;
            st_next = ST_WR;
          end
        end
      end
      ST_WR: begin
        if (!int_reg && MEM_ACK && MEM_ERR) begin
          mreq_next = 1'b0;
          set_flag[ERR_LSB + ch_reg] = 1'b1; // R24
          en_clr[ch_reg] = 1'b1; // R24
          st_next = ST_IDLE;
        end else if (wr_done) begin
          mreq_next = 1'b0;
          dwe = int_reg;
          dwi = didx(maddr_reg[9], maddr_reg[5:4], maddr_reg[3:2]); // R16
          burst_next = bst;
          cnt_next[c_idx] = is_last ? 10'h000 : cn;
          st_next = ST_IDLE;
          if (is_copy && cn[1:0] == 2'h0) begin // R13
            a_set[ch_reg] = 1'b1; // R18
            st_next = ST_FETCH; // R20
          end else if (is_last) begin
            if (calt_reg && ctype(ctl_reg) == CT_PSG) begin
              a_clr[ch_reg] = 1'b1; // R18
            end else if (ctype(ctl_reg) == CT_PINGPONG) begin // R3
              done_next[ch_reg] = 1'b1; // R2 R6
              set_flag[ch_reg] = 1'b1; // R2
              a_set[ch_reg] = !calt_reg; // R7
              a_clr[ch_reg] = calt_reg; // R7
            end else begin
              done_next[ch_reg] = 1'b1; // R6 R10
              set_flag[ch_reg] = 1'b1;
              en_clr[ch_reg] = 1'b1; // R10
            end
          end else if (!hit && en_cur) begin
            mreq_next = 1'b1;
            mwr_next = 1'b0;
            msize_next = ctl_reg[F_SS +: 2];
            maddr_next = xaddr(desc_reg[didx(calt_reg, ch_reg, W_SRC)],
                nm1(ctl_reg), cn, ctl_reg[F_SS +: 2]);
            st_next = ST_RD;
          end
        end
      end
      default: st_next = ST_IDLE;
    endcase

    // Only a fresh edge re-arms a channel after a pause
    pend_next = (pend_reg & ~clr_pend) | (rise & en_reg); // R21
    en_next = en_reg & ~en_clr;
    alt_next = (alt_reg | a_set) & ~a_clr;
    ie_next = ie_reg;
    prdata_next = prdata_reg;
    slverr_next = slverr_reg;
    if (apb_setup) begin
      slverr_next = 1'b0;
      prdata_next = 32'h0000_0000;
      case (PADDR)
        OFF_CH_EN: prdata_next = {29'h0, en_reg};
        OFF_ALT_STAT: prdata_next = {29'h0, alt_reg};
        OFF_ALT_SET, OFF_ALT_CLR: prdata_next = 32'h0000_0000;
        OFF_IRQ_EN: prdata_next = {26'h0, ie_reg};
        OFF_FLAGS: prdata_next = {26'h0, flag_reg};
        OFF_PEND: prdata_next = {29'h0, pend_reg};
        default: begin
          if (page_hit(PADDR) && PADDR[1:0] == 2'h0) begin
            prdata_next = desc_reg[didx(PADDR[9], PADDR[5:4], PADDR[3:2])];
          end else begin
            slverr_next = 1'b1;
          end
        end
      endcase
    end
    // Software writes override same-cycle hardware changes of enable/select
    if (apb_wr) begin
      case (PADDR)
        OFF_CH_EN: en_next = PWDATA[2:0];
        OFF_ALT_SET: alt_next = alt_reg | PWDATA[2:0];
        OFF_ALT_CLR: alt_next = alt_reg & ~PWDATA[2:0]; // R11 R19
        OFF_IRQ_EN: ie_next = PWDATA[5:0];
        OFF_FLAGS: w1c = PWDATA[5:0];
        // Read-only words must not fall through into the structure store
        OFF_ALT_STAT, OFF_PEND: w1c = 6'h00;
        default: begin
          if (!dwe && !slverr_reg) begin
            dwe = 1'b1;
            dwi = didx(PADDR[9], PADDR[5:4], PADDR[3:2]);
            dwd = PWDATA;
          end
        end
      endcase
    end
    // A hardware set beats a same-cycle software clear
    flag_next = (flag_reg & ~w1c) | set_flag;
    irq_next = |(flag_next & ie_reg); // R2 R24
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      st_reg <= ST_IDLE;
      ch_reg <= 2'h0;
      calt_reg <= 1'b0;
      ctl_reg <= 32'h0000_0000;
      burst_reg <= 11'h000;
      data_reg <= 32'h0000_0000;
      int_reg <= 1'b0;
      en_reg <= CH_EN_RST;
      alt_reg <= ALT_RST;
      pend_reg <= 3'h0;
      ie_reg <= IRQ_EN_RST;
      flag_reg <= FLAGS_RST;
      done_reg <= 3'h0;
      irq_reg <= 1'b0;
      for (int i = 0; i < 8; i++) cnt_reg[i] <= 10'h000;
      for (int i = 0; i < 24; i++) desc_reg[i] <= 32'h0000_0000;
      mreq_reg <= 1'b0;
      mwr_reg <= 1'b0;
      maddr_reg <= 32'h0000_0000;
      msize_reg <= SZ_WORD;
      mwdata_reg <= 32'h0000_0000;
      prdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      ch_reg <= ch_next;
      calt_reg <= calt_next;
      ctl_reg <= ctl_next;
      burst_reg <= burst_next;
      data_reg <= data_next;
      int_reg <= int_next;
      en_reg <= en_next;
      alt_reg <= alt_next;
      pend_reg <= pend_next;
      ie_reg <= ie_next;
      flag_reg <= flag_next;
      done_reg <= done_next;
      irq_reg <= irq_next;
      cnt_reg <= cnt_next;
      if (dwe) desc_reg[dwi] <= dwd;
      mreq_reg <= mreq_next;
      mwr_reg <= mwr_next;
      maddr_reg <= maddr_next;
      msize_reg <= msize_next;
      mwdata_reg <= mwdata_next;
      prdata_reg <= prdata_next;
      slverr_reg <= slverr_next;
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && slverr_reg;
  assign DMA_DONE = done_reg;
  assign IRQ = irq_reg;
  assign MEM_REQ = mreq_reg;
  assign MEM_WRITE = mwr_reg;
  assign MEM_ADDR = maddr_reg;
  assign MEM_SIZE = msize_reg;
  assign MEM_WDATA = mwdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  a_done_pulse: assert property ( // R6
    @(posedge CORE_CLK) disable iff (!NRST)
    (done_reg != 3'h0) |=> (done_reg == 3'h0))
    else $error("Done strobe longer than one cycle");

  a_pp_switch: assert property ( // R7
    @(posedge CORE_CLK) disable iff (!NRST)
    (wr_done && is_last && !is_copy && ctype(ctl_reg) == CT_PINGPONG &&
     !sw_alt) |=> (alt_cur != $past(alt_cur)) && (done_reg != 3'h0))
    else $error("Ping-pong end did not switch structure");

  a_pp_keep_en: assert property ( // R3
    @(posedge CORE_CLK) disable iff (!NRST)
    (wr_done && is_last && ctype(ctl_reg) == CT_PINGPONG && en_cur &&
     !sw_en) |=> en_cur)
    else $error("Ping-pong channel disabled after task");

  a_invalid_stop: assert property ( // R9
    @(posedge CORE_CLK) disable iff (!NRST)
    (st_reg == ST_FETCH && en_cur && ctype(fctl) == CT_INVALID &&
     !sw_en && !sw_alt) |=> (!en_cur && $stable(alt_cur) &&
     st_reg == ST_IDLE && !MEM_REQ))
    else $error("Invalid structure not handled");

  a_basic_stop: assert property ( // R10
    @(posedge CORE_CLK) disable iff (!NRST)
    (wr_done && is_last && !is_copy && ctype(ctl_reg) == CT_BASIC &&
     !sw_en && !sw_alt) |=> (!en_cur && $stable(alt_cur) &&
     done_reg != 3'h0))
    else $error("Basic successor did not end channel");

  a_burst_pause: assert property ( // R5
    @(posedge CORE_CLK) disable iff (!NRST)
    (wr_done && !is_last && !is_copy && hit) |=>
    (st_reg == ST_IDLE && !MEM_REQ))
    else $error("Burst did not pause for arbitration");

  a_copy_direct: assert property ( // R20
    @(posedge CORE_CLK) disable iff (!NRST)
    (wr_done && is_copy && cn[1:0] == 2'h0 && !sw_alt) |=>
    (st_reg == ST_FETCH && alt_cur) ##1 (st_reg != ST_IDLE || !en_cur ||
     ctype(ctl_reg) == CT_INVALID))
    else $error("Copy end did not go straight to alternate task");

  a_sg_reselect: assert property ( // R18
    @(posedge CORE_CLK) disable iff (!NRST)
    (wr_done && is_last && calt_reg && ctype(ctl_reg) == CT_PSG &&
     !sw_alt) |=> (!alt_cur && done_reg == 3'h0))
    else $error("Scatter task end did not reselect primary");

  a_err_stop: assert property ( // R24
    @(posedge CORE_CLK) disable iff (!NRST)
    (MEM_REQ && MEM_ACK && MEM_ERR && !sw_en) |=>
    (!en_cur && flag_reg[ERR_LSB + ch_reg] && st_reg == ST_IDLE))
    else $error("Bus error did not stop channel");

  a_done_cause: assert property ( // R23
    @(posedge CORE_CLK) disable iff (!NRST)
    (done_reg != 3'h0) |-> ($past(wr_done) && $past(is_last)))
    else $error("Done without final transfer");
endmodule

// ==== design/req_sync.sv ====
`timescale 1ns/1ps
module req_sync #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] rise
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] rise_next;

  // Edge is taken from the second and third stages only
  always_comb begin
    rise_next = s2_reg & ~s3_reg;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign rise = rise_next;
endmodule

// ==== include/dma_cycle_pkg.sv ====
package dma_cycle_pkg;

  localparam int NCH = 3;
  localparam int AW = 12;
  localparam int NW = 10;

  // Cycle type codes of the channel control word
  localparam logic [2:0] CT_INVALID = 3'h0;
  localparam logic [2:0] CT_BASIC = 3'h1;
  localparam logic [2:0] CT_PINGPONG = 3'h3;
  localparam logic [2:0] CT_PSG = 3'h6;

  // Width codes of source_width_field and dest_width_field
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;

  // Field positions in channel_control_word
  localparam int F_CT = 0;
  localparam int F_NM1 = 4;
  localparam int F_RP = 14;
  localparam int F_SS = 24;
  localparam int F_DS = 28;

  // Register offsets
  localparam logic [AW-1:0] OFF_CH_EN = 12'h000;
  localparam logic [AW-1:0] OFF_ALT_STAT = 12'h004;
  localparam logic [AW-1:0] OFF_ALT_SET = 12'h008;
  localparam logic [AW-1:0] OFF_ALT_CLR = 12'h00C;
  localparam logic [AW-1:0] OFF_IRQ_EN = 12'h010;
  localparam logic [AW-1:0] OFF_FLAGS = 12'h014;
  localparam logic [AW-1:0] OFF_PEND = 12'h018;
  localparam logic [3:0] DESC_PRI_PAGE = 4'h1;
  localparam logic [3:0] DESC_ALT_PAGE = 4'h2;
  localparam logic [19:0] DESC_SYS_PAGE = 20'h5_0080;

  // Word slots inside one control structure
  localparam logic [1:0] W_SRC = 2'h0;
  localparam logic [1:0] W_DST = 2'h1;
  localparam logic [1:0] W_CTRL = 2'h2;

  // Reset values
  localparam logic [2:0] CH_EN_RST = 3'h0;
  localparam logic [2:0] ALT_RST = 3'h0;
  localparam logic [5:0] IRQ_EN_RST = 6'h00;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam int ERR_LSB = 3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_RD = 4'b0100,
    ST_WR = 4'b1000
  } state_t;

endpackage

// ==== test/mem_model.sv ====
`timescale 1ns/1ps
module mem_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req,
  input wire logic write,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] lat,
  output logic [31:0] rdata,
  output logic ack,
  output logic err
);
  logic [31:0] mem [logic [31:0]];
  int cnt;
  int n_rd;
  int n_wr;
  logic [31:0] last_waddr;
  logic [31:0] last_wdata;
  ////////////////////////////////////////////////////////////////////////
  // Idle read data toggles so a stale word is never taken for a fresh one
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack <= 1'b0;
      err <= 1'b0;
      rdata <= 32'h0000_0000;
      cnt <= 0;
      n_rd <= 0;
      n_wr <= 0;
    end else begin
      ack <= 1'b0;
      err <= 1'b0;
      rdata <= ~rdata;
      if (req && !ack) begin
        if (cnt < int'(lat)) begin
          cnt <= cnt + 1;
        end else begin
          cnt <= 0;
          ack <= 1'b1;
          // Top page is unmapped space
          err <= (addr[31:28] == 4'hF);
          if (write) begin
            mem[addr] = wdata;
            last_waddr <= addr;
            last_wdata <= wdata;
            n_wr <= n_wr + 1;
          end else begin
            rdata <= mem.exists(addr) ? mem[addr] : addr ^ 32'h5A5A_5A5A;
            n_rd <= n_rd + 1;
          end
        end
      end
    end
  end
endmodule

// ==== test/tb_dma_pingpong_scatter_cycle.sv ====
`timescale 1ns/1ps
module tb_dma_pingpong_scatter_cycle;
  import dma_cycle_pkg::*;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, irq, se;
  logic mreq, mwr, mack, merr;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, mrdata, maddr, mwdata, q;
  logic [NCH-1:0] dreq, ddone;
  logic [1:0] msize;
  logic [3:0] lat;
  int n_mismatch, n_compared, b, r;
  int nd [NCH];
  dma_pingpong_scatter_cycle i_dma_pingpong_scatter_cycle (.CORE_CLK(clk),
    .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .DMA_REQ(dreq), .DMA_DONE(ddone), .IRQ(irq),
    .MEM_REQ(mreq), .MEM_WRITE(mwr), .MEM_ADDR(maddr), .MEM_SIZE(msize),
    .MEM_WDATA(mwdata), .MEM_RDATA(mrdata), .MEM_ACK(mack), .MEM_ERR(merr));
  mem_model i_mem_model (.clk(clk), .nrst(nrst), .req(mreq), .write(mwr),
    .addr(maddr), .wdata(mwdata), .lat(lat), .rdata(mrdata), .ack(mack),
    .err(merr));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Sampled mid-cycle so a registered pulse is counted once per cycle
  always @(negedge clk) begin
    for (int i = 0; i < NCH; i++) if (ddone[i] === 1'b1) nd[i]++;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] ctl(input logic [2:0] t,
    input logic [9:0] n, input logic [3:0] p);
    ctl = 32'h0000_0000;
    ctl[F_CT +: 3] = t;
    ctl[F_NM1 +: 10] = n;
    ctl[F_RP +: 4] = p;
    ctl[F_SS +: 2] = SZ_WORD;
    ctl[F_DS +: 2] = SZ_WORD;
  endfunction
  task automatic chk(input string n, input logic [31:0] s,
    input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [AW-1:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [31:0] e,
    input string n);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, q, e);
  endtask
  task automatic st(input logic [AW-1:0] a, input logic [31:0] s,
    input logic [31:0] d, input logic [31:0] c);
    apb(1'b1, a, s);
    apb(1'b1, a + 12'h004, d);
    apb(1'b1, a + 12'h008, c);
  endtask
  // A fresh edge for every pause and every copy
  task automatic pulse(input int c);
    @(posedge clk);
    dreq[c] <= 1'b1;
    repeat (4) @(posedge clk);
    dreq[c] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic wait_wr(input int n);
    int k;
    k = 0;
    while (i_mem_model.n_wr < n && k < 500) begin
      @(posedge clk);
      k++;
    end
    repeat (12) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_pingpong;
    apb(1'b1, OFF_ALT_CLR, 32'h0000_0001);
    st(12'h100, 32'h2000_0014, 32'h3000_0014,
      ctl(CT_PINGPONG, 10'h005, 4'h2));
    st(12'h200, 32'h2000_0104, 32'h3000_0104,
      ctl(CT_PINGPONG, 10'h001, 4'h2));
    apb(1'b1, OFF_IRQ_EN, 32'h0000_0001);
    apb(1'b1, OFF_CH_EN, 32'h0000_0001);
    b = i_mem_model.n_wr;
    pulse(0);
    wait_wr(b + 4);
    chk("burst", 32'(i_mem_model.n_wr - b), 32'd4);
    pulse(0);
    wait_wr(b + 6);
    chk("task a", 32'(i_mem_model.n_wr - b), 32'd6);
    chk("done a", 32'(nd[0]), 32'd1);
    chk("addr a", i_mem_model.last_waddr, 32'h3000_0014);
    chk("data a", i_mem_model.last_wdata, 32'h7A5A_5A4E);
    chk("irq a", {31'b0, irq}, 32'd1);
    rd(OFF_ALT_STAT, 32'h0000_0001, "alt a");
    rd(OFF_CH_EN, 32'h0000_0001, "en a");
    apb(1'b1, OFF_FLAGS, 32'h0000_0001);
    apb(1'b1, 12'h108, ctl(CT_BASIC, 10'h000, 4'h2));
    lat <= 4'h3;
    pulse(0);
    wait_wr(b + 8);
    chk("done b", 32'(nd[0]), 32'd2);
    chk("addr b", i_mem_model.last_waddr, 32'h3000_0104);
    rd(OFF_ALT_STAT, 32'h0000_0000, "alt b");
    pulse(0);
    wait_wr(b + 9);
    chk("done c", 32'(nd[0]), 32'd3);
    rd(OFF_CH_EN, 32'h0000_0000, "en c");
    rd(OFF_ALT_STAT, 32'h0000_0000, "alt c");
    apb(1'b1, OFF_ALT_SET, 32'h0000_0001);
    apb(1'b1, 12'h208, ctl(CT_INVALID, 10'h000, 4'h2));
    apb(1'b1, OFF_CH_EN, 32'h0000_0001);
    pulse(0);
    repeat (20) @(posedge clk);
    chk("no data", 32'(i_mem_model.n_wr - b), 32'd9);
    rd(OFF_CH_EN, 32'h0000_0000, "en d");
    rd(OFF_ALT_STAT, 32'h0000_0001, "alt d");
    $display("test pingpong done");
  endtask
  task automatic t_scatter;
    logic [31:0] d [8];
    d = '{32'h2000_2008, 32'h3000_2008, ctl(CT_PSG, 10'h002, 4'h2),
      32'h0000_00A1, 32'h2000_3004, 32'h3000_3004,
      ctl(CT_BASIC, 10'h001, 4'h2), 32'h0000_00B2};
    for (int i = 0; i < 8; i++) begin
      i_mem_model.mem[32'h2000_0FE4 + 32'(4 * i)] = d[i];
    end
    apb(1'b1, OFF_ALT_CLR, 32'h0000_0002);
    st(12'h110, 32'h2000_1000, 32'h5008_021C,
      ctl(CT_PSG, 10'h007, 4'h2));
    apb(1'b1, OFF_CH_EN, 32'h0000_0002);
    b = i_mem_model.n_wr;
    r = i_mem_model.n_rd;
    lat <= 4'h0;
    pulse(1);
    wait_wr(b + 3);
    chk("reads a", 32'(i_mem_model.n_rd - r), 32'd7);
    chk("addr a", i_mem_model.last_waddr, 32'h3000_2008);
    chk("done a", 32'(nd[1]), 32'd0);
    rd(OFF_ALT_STAT, 32'h0000_0001, "alt a");
    for (int i = 0; i < 4; i++) rd(12'h210 + 12'(4 * i), d[i], "desc");
    pulse(1);
    wait_wr(b + 5);
    chk("done b", 32'(nd[1]), 32'd1);
    rd(12'h218, d[6], "desc b");
    rd(OFF_CH_EN, 32'h0000_0000, "en b");
    $display("test scatter done");
  endtask
  task automatic t_error;
    st(12'h120, 32'h2000_4000, 32'hF000_0000,
      ctl(CT_PINGPONG, 10'h000, 4'h2));
    apb(1'b1, OFF_IRQ_EN, 32'h0000_0020);
    apb(1'b1, OFF_CH_EN, 32'h0000_0004);
    pulse(2);
    repeat (20) @(posedge clk);
    apb(1'b0, OFF_FLAGS, 32'h0000_0000);
    chk("err flag", q & 32'h0000_0020, 32'h0000_0020);
    chk("irq err", {31'b0, irq}, 32'd1);
    chk("done err", 32'(nd[2]), 32'd0);
    rd(OFF_CH_EN, 32'h0000_0000, "en err");
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk("unmapped", {31'b0, se}, 32'd1);
    $display("test error done");
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results;
  end
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    dreq = '0;
    lat = 4'h0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_pingpong;
    t_scatter;
    t_error;
    results;
  end
endmodule
